// file: pil_pkg.sv
// Constants for the interrupt latch and mask block.
// Assumes a 100 MHz system clock and an AXI4-Lite master.
`default_nettype none
package pil_pkg;
    localparam int CLK_MHZ = 100;
    localparam int NUM_EVT = 14;
    localparam int NUM_DB = 4;
    localparam int CNT_W = 24;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_SENSE = 8'h08;
    localparam logic [7:0] OFS_DBCFG = 8'h0C;

    // Event bit positions
    localparam int BIT_CONV_DONE = 0;
    localparam int BIT_TOUCH_DONE = 1;
    localparam int BIT_PEN = 2;
    localparam int BIT_OVERVOLT = 3;
    localparam int BIT_BATT_LOW = 4;
    localparam int BIT_BUS_PWR = 5;
    localparam int BIT_JAM_RCV = 6;
    localparam int BIT_JAM = 7;
    localparam int BIT_CONV_CHG = 8;
    localparam int BIT_UNKNOWN_ACC = 9;
    localparam int BIT_LONG_REL = 10;
    localparam int BIT_LONG_PRESS = 11;
    localparam int BIT_PRESS = 12;
    localparam int BIT_DETACH = 13;

    // Sense bit positions
    localparam int SNS_OVERVOLT = 0;
    localparam int SNS_BUS_PWR = 1;
    localparam int SNS_CONV_READY = 2;
    localparam int SNS_W = 3;

    // Debounce select fields in the config register
    localparam int DBCFG_OVP_LSB = 0;
    localparam int DBCFG_BATT_LSB = 2;
    localparam int DBCFG_VBUS_LSB = 4;
    localparam int DBCFG_W = 6;

    // Edge sensitivity per event bit
    localparam logic [NUM_EVT-1:0] TRIG_RISE = 14'h3FEF;
    localparam logic [NUM_EVT-1:0] TRIG_FALL = 14'h003C;
    // Debounced channels 0..3 map onto event bits 2..5
    localparam int DB_BASE = 2;

    localparam logic [NUM_EVT-1:0] MASK_RST = 14'h3FFF;
    localparam logic [NUM_EVT-1:0] STATUS_RST = 14'h0000;
    localparam logic [DBCFG_W-1:0] DBCFG_RST = 6'h00;

    // Debounce times in microseconds, then the same times in clock cycles
    localparam int PEN_DB_US = 1000;
    localparam int SEL0_DB_US = 100;
    localparam int SEL1_DB_US = 1000;
    localparam int SEL2_DB_US = 10000;
    localparam int SEL3_DB_US = 30000;
    localparam int PEN_DB_CYC = PEN_DB_US * CLK_MHZ;
    localparam int SEL0_DB_CYC = SEL0_DB_US * CLK_MHZ;
    localparam int SEL1_DB_CYC = SEL1_DB_US * CLK_MHZ;
    localparam int SEL2_DB_CYC = SEL2_DB_US * CLK_MHZ;
    localparam int SEL3_DB_CYC = SEL3_DB_US * CLK_MHZ;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pil_pkg
`default_nettype wire

// file: pil_top.sv
// Interrupt latch, mask and sense block with an AXI4-Lite register port.
// Event pins are asynchronous levels; the bus runs on CLK_I.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1: IRQ high while unmasked status is set
// RQ2: Events latch into sticky status bits
// RQ3: Writing one clears a status bit
// RQ4: New event during clear keeps IRQ high
// RQ5: Mask bit one blocks the IRQ
// RQ6: Masked events still latch and read back
// RQ7: All mask bits set at reset
// RQ8: Unmasking a pending bit raises IRQ
// RQ9: Sense bits live, read only, unlatched
// RQ10: External events latch after stable debounce
// RQ11: Conversion done events rise, no debounce
// RQ12: Pen detect both edges, 1 ms debounce
// RQ13: Overvoltage both edges, programmable debounce, sense
// RQ14: Battery low latches on falling, debounced
// RQ15: Result changed rises; sense shows completion
// RQ16: Accessory and button events latch rising
// RQ17: Debounce interval may vary slightly
// RQ18: Writing zero leaves status bits alone
module pil_top
    import pil_pkg::*;
#(
    parameter int PEN_CYC = PEN_DB_CYC,
    parameter int SEL0_CYC = SEL0_DB_CYC,
    parameter int SEL1_CYC = SEL1_DB_CYC,
    parameter int SEL2_CYC = SEL2_DB_CYC,
    parameter int SEL3_CYC = SEL3_DB_CYC
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CONV_DONE_EVT_I,
    input wire logic TOUCH_CONV_DONE_EVT_I,
    input wire logic PEN_DETECT_EVT_I,
    input wire logic BUS_OVERVOLT_EVT_I,
    input wire logic BATTERY_LOW_EVT_I,
    input wire logic BUS_POWER_PRESENT_EVT_I,
    input wire logic JAMMED_BUTTON_RECOVER_EVT_I,
    input wire logic JAMMED_BUTTON_EVT_I,
    input wire logic CONV_RESULT_CHANGED_EVT_I,
    input wire logic UNKNOWN_ACCESSORY_EVT_I,
    input wire logic LONG_BUTTON_RELEASE_EVT_I,
    input wire logic LONG_BUTTON_PRESS_EVT_I,
    input wire logic BUTTON_PRESS_EVT_I,
    input wire logic DETACH_EVT_I,
    input wire logic CONV_READY_I,
    input wire logic [7:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [7:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic IRQ_O
);

    typedef struct packed {
        logic [NUM_EVT:0] sync1;
        logic [NUM_EVT:0] sync2;
        logic [NUM_EVT-1:0] prev;
        logic [NUM_DB-1:0] flt;
        logic [NUM_DB-1:0][CNT_W-1:0] cnt;
        logic [NUM_EVT-1:0] status;
        logic [NUM_EVT-1:0] mask;
        logic [DBCFG_W-1:0] dbcfg;
        logic irq;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pil_state_type;

    pil_state_type st_reg;
    pil_state_type st_next;

    logic [NUM_EVT:0] pins;
    logic [NUM_EVT-1:0] lvl;
    logic [NUM_EVT-1:0] set_evt;
    logic [NUM_EVT-1:0] clr_evt;
    logic [NUM_DB-1:0][CNT_W-1:0] period;
    logic [SNS_W-1:0] sense;
    logic aw_have;
    logic w_have;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;

    assign pins = {CONV_READY_I, DETACH_EVT_I, BUTTON_PRESS_EVT_I,
        LONG_BUTTON_PRESS_EVT_I, LONG_BUTTON_RELEASE_EVT_I,
        UNKNOWN_ACCESSORY_EVT_I, CONV_RESULT_CHANGED_EVT_I,
        JAMMED_BUTTON_EVT_I, JAMMED_BUTTON_RECOVER_EVT_I,
        BUS_POWER_PRESENT_EVT_I, BATTERY_LOW_EVT_I, BUS_OVERVOLT_EVT_I,
        PEN_DETECT_EVT_I, TOUCH_CONV_DONE_EVT_I, CONV_DONE_EVT_I};

    function automatic logic [CNT_W-1:0] sel_cyc(input logic [1:0] sel);
        logic [CNT_W-1:0] r;
        case (sel)
            2'h0: r = CNT_W'(SEL0_CYC);
            2'h1: r = CNT_W'(SEL1_CYC);
            2'h2: r = CNT_W'(SEL2_CYC);
            default: r = CNT_W'(SEL3_CYC);
        endcase
        return r;
    endfunction : sel_cyc

    always_comb begin
        st_next = st_reg;
        // Two stages before any logic looks at a pin
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;

        // RQ12 pen detect fixed period
        period[0] = CNT_W'(PEN_CYC);
        // RQ13 overvoltage programmable period
        period[1] = sel_cyc(st_reg.dbcfg[DBCFG_OVP_LSB +: 2]);
        // RQ14 battery low programmable period
        period[2] = sel_cyc(st_reg.dbcfg[DBCFG_BATT_LSB +: 2]);
        period[3] = sel_cyc(st_reg.dbcfg[DBCFG_VBUS_LSB +: 2]);

        // RQ11 undebounced channels use synced level
        lvl = st_reg.sync2[NUM_EVT-1:0];
        for (int i = 0; i < NUM_DB; i++) begin
            // RQ10 flip only after full stable period
            if (st_reg.sync2[DB_BASE + i] != st_reg.flt[i]) begin
                // RQ17 timer counts only while the pin differs from the filtered level
                if (st_reg.cnt[i] + CNT_W'(1) >= period[i]) begin
                    st_next.flt[i] = st_reg.sync2[DB_BASE + i];
                    st_next.cnt[i] = '0;
                end else begin
                    st_next.cnt[i] = st_reg.cnt[i] + CNT_W'(1);
                end
            end else begin
                st_next.cnt[i] = '0;
            end
            lvl[DB_BASE + i] = st_reg.flt[i];
        end
        st_next.prev = lvl;

        // RQ16 rising or falling per event bit
        set_evt = (lvl & ~st_reg.prev & TRIG_RISE) | (~lvl & st_reg.prev & TRIG_FALL);

        // RQ9 live sense, never latched
        sense = '0;
        sense[SNS_OVERVOLT] = st_reg.sync2[BIT_OVERVOLT];
        sense[SNS_BUS_PWR] = st_reg.sync2[BIT_BUS_PWR];
        // RQ15 one when conversion complete
        sense[SNS_CONV_READY] = st_reg.sync2[NUM_EVT];

        // Write channel: address and data taken in either order
        aw_have = st_reg.aw_got | (AWVALID_I & st_reg.awready);
        w_have = st_reg.w_got | (WVALID_I & st_reg.wready);
        wa = st_reg.aw_got ? st_reg.awaddr : AWADDR_I;
        wd = st_reg.w_got ? st_reg.wdata : WDATA_I;
        ws = st_reg.w_got ? st_reg.wstrb : WSTRB_I;
        if (AWVALID_I && st_reg.awready) begin
            st_next.awready = 1'b0;
            st_next.aw_got = 1'b1;
            st_next.awaddr = AWADDR_I;
        end
        if (WVALID_I && st_reg.wready) begin
            st_next.wready = 1'b0;
            st_next.w_got = 1'b1;
            st_next.wdata = WDATA_I;
            st_next.wstrb = WSTRB_I;
        end

        clr_evt = '0;
        if (aw_have && w_have && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            if (wa[7:2] == OFS_STATUS[7:2]) begin
                // RQ3 write one to clear
                // RQ18 zero bits and lanes untouched
                for (int b = 0; b < NUM_EVT; b++) begin
                    if (ws[b / 8] && wd[b]) begin
                        clr_evt[b] = 1'b1;
                    end
                end
            end else if (wa[7:2] == OFS_MASK[7:2]) begin
                for (int b = 0; b < NUM_EVT; b++) begin
                    if (ws[b / 8]) begin
                        st_next.mask[b] = wd[b];
                    end
                end
            end else if (wa[7:2] == OFS_DBCFG[7:2]) begin
                if (ws[0]) begin
                    st_next.dbcfg = wd[DBCFG_W-1:0];
                end
            end else if (wa[7:2] == OFS_SENSE[7:2]) begin
                // RQ9 sense ignores writes
                st_next.bresp = RESP_OKAY;
            end else begin
                st_next.bresp = RESP_SLVERR;
            end
        end
        if (st_reg.bvalid && BREADY_I) begin
            st_next.bvalid = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
        end

        // RQ2 sticky until cleared
        // RQ6 latching ignores the mask
        // RQ4 set wins over clear
        st_next.status = (st_reg.status & ~clr_evt) | set_evt;

        // Read channel: one cycle from address to data
        if (ARVALID_I && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            st_next.rdata = '0;
            if (ARADDR_I[7:2] == OFS_STATUS[7:2]) begin
                st_next.rdata[NUM_EVT-1:0] = st_reg.status;
            end else if (ARADDR_I[7:2] == OFS_MASK[7:2]) begin
                st_next.rdata[NUM_EVT-1:0] = st_reg.mask;
            end else if (ARADDR_I[7:2] == OFS_SENSE[7:2]) begin
                st_next.rdata[SNS_W-1:0] = sense;
            end else if (ARADDR_I[7:2] == OFS_DBCFG[7:2]) begin
                st_next.rdata[DBCFG_W-1:0] = st_reg.dbcfg;
            end else begin
                st_next.rresp = RESP_SLVERR;
            end
        end
        if (st_reg.rvalid && RREADY_I) begin
            st_next.rvalid = 1'b0;
            st_next.arready = 1'b1;
        end

        // RQ1 level output from latched, unmasked bits
        // RQ5 mask one blocks the line
        // RQ8 follows the new mask at once
        st_next.irq = |(st_next.status & ~st_next.mask);

        if (!NRST_I) begin
            st_next = '0;
            // RQ7 everything masked out of reset
            st_next.mask = MASK_RST;
            st_next.status = STATUS_RST;
            st_next.dbcfg = DBCFG_RST;
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
            st_next.arready = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        st_reg <= st_next;
    end

    assign AWREADY_O = st_reg.awready;
    assign WREADY_O = st_reg.wready;
    assign BVALID_O = st_reg.bvalid;
    assign BRESP_O = st_reg.bresp;
    assign ARREADY_O = st_reg.arready;
    assign RVALID_O = st_reg.rvalid;
    assign RDATA_O = st_reg.rdata;
    assign RRESP_O = st_reg.rresp;
    assign IRQ_O = st_reg.irq;

endmodule : pil_top
`default_nettype wire

// file: pil_sva.sv
// Bus handshake and interrupt line properties.
// Bound to pil_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module pil_sva (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic AWVALID_I,
    input wire logic AWREADY_O,
    input wire logic WVALID_I,
    input wire logic WREADY_O,
    input wire logic [1:0] BRESP_O,
    input wire logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic ARVALID_I,
    input wire logic ARREADY_O,
    input wire logic [31:0] RDATA_O,
    input wire logic RVALID_O,
    input wire logic RREADY_I,
    input wire logic IRQ_O
);
    logic wrote_reg;
    // All sources masked until software writes something
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) wrote_reg <= 1'b0;
        else if (BVALID_O) wrote_reg <= 1'b1;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    property p_wr_ans; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |=> BVALID_O; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_rd_ans; ARVALID_I && ARREADY_O |=> RVALID_O ##0 !ARREADY_O; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_b_hold; BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_b_done; BVALID_O && BREADY_I |=> !BVALID_O && AWREADY_O && WREADY_O; endproperty
    a_b_done: assert property (p_b_done) else $error("write not retired");
    property p_sticky; $fell(IRQ_O) |-> $rose(BVALID_O); endproperty
    a_sticky: assert property (p_sticky) else $error("irq fell without write");
    property p_masked; $rose(IRQ_O) |-> wrote_reg || BVALID_O; endproperty
    a_masked: assert property (p_masked) else $error("irq before unmask");
    property p_one_wr; BVALID_O |-> !AWREADY_O && !WREADY_O; endproperty
    a_one_wr: assert property (p_one_wr) else $error("second write taken");
endmodule : pil_sva
`default_nettype wire

// file: pil_host.sv
// Host processor model: AXI4-Lite master, may stall its responses.
// Runs on the block clock; one write and one read at a time.
`timescale 1ns/1ps
`default_nettype none
module pil_host (
    input wire logic clk_i,
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    int slow = 0;
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk_i);
        awaddr_o <= a;
        awvalid_o <= 1'b1;
        wdata_o <= d;
        wstrb_o <= 4'hF;
        wvalid_o <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (awready_i) awvalid_o <= 1'b0;
            if (wready_i) wvalid_o <= 1'b0;
            // Released address and data lines churn rather than hold stale values; strobes hold
            if (!awvalid_o) awaddr_o <= ~awaddr_o;
            if (!wvalid_o) wdata_o <= ~wdata_o;
            if (bready_o && bvalid_i) break;
            if (bvalid_i && n++ >= slow) bready_o <= 1'b1;
        end
        r = bresp_i;
        bready_o <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (arready_i) arvalid_o <= 1'b0;
            if (!arvalid_o) araddr_o <= ~araddr_o;
            if (rready_o && rvalid_i) break;
            if (rvalid_i && n++ >= slow) rready_o <= 1'b1;
        end
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask : rd
endmodule : pil_host
`default_nettype wire

// file: pil_top_bench.sv
// Self-checking bench for pil_top with short debounce counts.
// Host model drives the bus; event pins driven here.
`timescale 1ns/1ps
`default_nettype none
module pil_top_bench
    import pil_pkg::*;
;
    logic clk, nrst, rdy, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [13:0] evt;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [5:0] cfg;
    int err_total = 0, num_checks = 0, cyc = 0, n;
    logic watch = 1'b0, dropped = 1'b0;
    // Catches even a one-cycle dip of the line
    always @(posedge clk) begin
        if (watch && !irq) dropped <= 1'b1;
    end
    pil_top #(.PEN_CYC(4), .SEL0_CYC(4), .SEL1_CYC(6), .SEL2_CYC(8), .SEL3_CYC(10)) uut (
        .CLK_I(clk), .NRST_I(nrst), .CONV_DONE_EVT_I(evt[0]), .TOUCH_CONV_DONE_EVT_I(evt[1]),
        .PEN_DETECT_EVT_I(evt[2]), .BUS_OVERVOLT_EVT_I(evt[3]), .BATTERY_LOW_EVT_I(evt[4]),
        .BUS_POWER_PRESENT_EVT_I(evt[5]), .JAMMED_BUTTON_RECOVER_EVT_I(evt[6]),
        .JAMMED_BUTTON_EVT_I(evt[7]), .CONV_RESULT_CHANGED_EVT_I(evt[8]),
        .UNKNOWN_ACCESSORY_EVT_I(evt[9]), .LONG_BUTTON_RELEASE_EVT_I(evt[10]),
        .LONG_BUTTON_PRESS_EVT_I(evt[11]), .BUTTON_PRESS_EVT_I(evt[12]), .DETACH_EVT_I(evt[13]),
        .CONV_READY_I(rdy), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
        .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
        .RREADY_I(rready), .IRQ_O(irq));
    pil_host u_host (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
        .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
        .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    // Debounce length of an event bit under the current select field
    function automatic int per(input int b);
        logic [1:0] s;
        s = b == 3 ? cfg[1:0] : b == 4 ? cfg[3:2] : cfg[5:4];
        return (b < 3 || b > 5) ? 4 : 4 + 2 * s;
    endfunction : per
    function automatic logic [31:0] exp_st(input int b, input int n);
        return (b >= 2 && b <= 5 && n < per(b)) ? 32'h0 : 32'h1 << b;
    endfunction : exp_st
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        u_host.rd(a, d, r);
        chk("rdata", e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rc
    task automatic pulse(input int b, input int len);
        evt[b] <= ~evt[b];
        repeat (len) @(posedge clk);
        evt[b] <= ~evt[b];
        repeat (20) @(posedge clk);
    endtask : pulse
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        seed = $urandom(75);
        evt = 14'h0010;
        nrst = 0;
        rdy = 0;
        repeat (5) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        rc(OFS_MASK, 32'h3FFF, RESP_OKAY);
        rc(OFS_STATUS, 32'h0, RESP_OKAY);
        cfg = 6'($urandom);
        u_host.wr(OFS_DBCFG, {26'h0, cfg}, r);
        rc(OFS_DBCFG, {26'h0, cfg}, RESP_OKAY);
        rdy <= 1'($urandom);
        evt[3] <= 1'b1;
        evt[5] <= 1'b1;
        repeat (20) @(posedge clk);
        u_host.wr(OFS_SENSE, 32'h0, r);
        rc(OFS_SENSE, {29'h0, rdy, 2'b11}, RESP_OKAY);
        evt[3] <= 1'b0;
        evt[5] <= 1'b0;
        repeat (20) @(posedge clk);
        rc(OFS_SENSE, {29'h0, rdy, 2'b00}, RESP_OKAY);
        u_host.wr(OFS_STATUS, 32'h3FFF, r);
        // Two pulses per source, each randomly long or a short glitch, all masked
        for (int i = 0; i < 2 * NUM_EVT; i++) begin
            u_host.slow = $urandom % 3;
            n = ($urandom % 2) ? per(i % NUM_EVT) + 3 : per(i % NUM_EVT) - 2;
            pulse(i % NUM_EVT, n);
            rc(OFS_STATUS, exp_st(i % NUM_EVT, n), RESP_OKAY);
            u_host.wr(OFS_STATUS, 32'h3FFF, r);
            chk("irq", 32'h0, {31'h0, irq});
        end
        pulse(12, 3);
        u_host.wr(OFS_MASK, 32'h0, r);
        chk("irq", 32'h1, {31'h0, irq});
        pulse(0, 3);
        u_host.wr(OFS_STATUS, 32'h0, r);
        rc(OFS_STATUS, 32'h1001, RESP_OKAY);
        u_host.wr(OFS_STATUS, 32'h1, r);
        chk("irq", 32'h1, {31'h0, irq});
        u_host.wr(OFS_MASK, 32'h1000, r);
        chk("irq", 32'h0, {31'h0, irq});
        rc(OFS_STATUS, 32'h1000, RESP_OKAY);
        u_host.wr(OFS_MASK, 32'h0, r);
        // New event lands while another bit is cleared
        // Pin needs three edges, the write two: both land on one edge
        evt[1] <= 1'b1;
        watch <= 1'b1;
        @(posedge clk);
        u_host.wr(OFS_STATUS, 32'h1000, r);
        evt[1] <= 1'b0;
        repeat (4) @(posedge clk);
        watch <= 1'b0;
        chk("irq", 32'h1, {31'h0, irq});
        chk("irq_dip", 32'h0, {31'h0, dropped});
        rc(OFS_STATUS, 32'h2, RESP_OKAY);
        u_host.wr(OFS_STATUS, 32'h2, r);
        chk("irq", 32'h0, {31'h0, irq});
        u_host.wr(8'h10, 32'h0, r);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        rc(8'h10, 32'h0, RESP_SLVERR);
        conclude();
    end
endmodule : pil_top_bench
bind pil_top pil_sva u_sva (.CLK_I(CLK_I), .NRST_I(NRST_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O),
    .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
    .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .IRQ_O(IRQ_O));
`default_nettype wire
